// file: verilog/pmt_target.sv
// serial bus target front end with timeout, idle reset and stretch limit
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - target only; accepts transfers with serial clock 10 to 400 kHz.
// - clock line low over 35 ms: timeout, abandon current transfer.
// - both lines high over 50 ms: reset any transaction in progress.
// - idle reset only while the timeout disable bit is cleared.
// - total clock stretching per message stays within 25 ms.
// - bytes are handed to the command layer in PMBus 1.1 order.
// - manufacturer commands pass through the same byte path.
// - SMBus 1.1 behaviour including an ALERT output and response.
module pmt_target
  import pmt_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = pmt_pkg::TIMEOUT_CYC,
  parameter int unsigned IDLE_CYCLES = pmt_pkg::IDLE_CYC,
  parameter int unsigned STRETCH_CYCLES = pmt_pkg::STRETCH_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic serial_clock_line,
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe,
  output logic alert_n_out,
  output logic alert_n_oe,
  input wire logic [6:0] own_addr,
  input wire logic smbus_timeout_disable_bit,
  input wire logic alert_req,
  input wire logic hold_req,
  input wire logic [7:0] tx_data,
  output pmt_pkg::pmt_byte_s rx_byte,
  output logic rx_read,
  output logic bus_stop,
  output logic timeout_evt,
  output logic idle_reset_evt
);
  import pmt_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] pins_s;
  pmt_sync #(.WIDTH(2)) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .ce(clk_en),
    .d({serial_clock_line, serial_data_line_in}),
    .q(pins_s)
  );

  wire scl = pins_s[1];
  wire sda = pins_s[0];
  logic scl_d_reg;
  logic sda_d_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else if (clk_en) begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
    end
  end

  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire start_det = scl & scl_d_reg & sda_d_reg & ~sda;
  wire stop_det = scl & scl_d_reg & ~sda_d_reg & sda;

  // ---------------------------------------------------------------
  // timers
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] idle_cnt_reg;
  logic [CNT_W-1:0] str_cnt_reg;
  logic stretching;
  logic in_msg_reg;

  wire timeout_hit = (low_cnt_reg == CNT_W'(TIMEOUT_CYCLES));
  wire idle_hit = (idle_cnt_reg == CNT_W'(IDLE_CYCLES));
  // disable bit gates the idle reset
  wire idle_abort = idle_hit & ~smbus_timeout_disable_bit & in_msg_reg;
  wire str_spent = (str_cnt_reg >= CNT_W'(STRETCH_CYCLES));
  wire abort = timeout_hit | idle_abort;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_reg <= '0;
      idle_cnt_reg <= '0;
      str_cnt_reg <= '0;
    end else if (clk_en) begin
      if (scl || timeout_hit) low_cnt_reg <= '0;
      else low_cnt_reg <= low_cnt_reg + 1'b1;
      if (!(scl && sda) || idle_hit) idle_cnt_reg <= '0;
      else idle_cnt_reg <= idle_cnt_reg + 1'b1;
      if (start_det && !in_msg_reg) str_cnt_reg <= '0;
      else if (stretching && !str_spent) str_cnt_reg <= str_cnt_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // byte engine
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    PMT_IDLE,
    PMT_ADDR,
    PMT_ACK,
    PMT_RX,
    PMT_TX,
    PMT_TXACK,
    PMT_SKIP
  } pmt_state_e;

  pmt_state_e st_reg;
  pmt_state_e st_next;
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic rd_reg;
  logic first_reg;
  logic ara_reg;
  logic sda_drv_reg;

  wire addr_match = (sh_reg[7:1] == own_addr);
  // alert response address answers with own address
  wire ara_match = (sh_reg == ARA_ADDR) & alert_req;
  wire bit_done = (bit_reg == 4'h8);
  assign stretching = hold_req & ~scl & (st_reg == PMT_ACK) & ~str_spent;

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      PMT_IDLE: st_next = PMT_IDLE;
      PMT_ADDR: begin
        if (scl_fall && bit_done) begin
          st_next = (addr_match || ara_match) ? PMT_ACK : PMT_SKIP;
        end
      end
      PMT_ACK: begin
        // leave on the host's fall; waiting here would lose a bit
        if (scl_fall) begin
          st_next = rd_reg ? PMT_TX : PMT_RX;
        end
      end
      PMT_RX: if (scl_fall && bit_done) st_next = PMT_ACK;
      PMT_TX: if (scl_fall && bit_done) st_next = PMT_TXACK;
      PMT_TXACK: if (scl_rise) st_next = sda ? PMT_SKIP : PMT_TX;
      PMT_SKIP: st_next = PMT_SKIP;
      default: st_next = PMT_IDLE;
    endcase
    // abort and stop return to idle
    if (abort || stop_det) st_next = PMT_IDLE;
    // target only: every transfer opens with host start
    if (start_det && !abort) st_next = PMT_ADDR;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= PMT_IDLE;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      rd_reg <= 1'b0;
      first_reg <= 1'b0;
      ara_reg <= 1'b0;
    end else if (clk_en) begin
      if (start_det || st_next == PMT_ACK || st_next == PMT_TXACK) begin
        bit_reg <= 4'h0;
      end else if (scl_rise && (st_reg == PMT_ADDR || st_reg == PMT_RX)) begin
        sh_reg <= {sh_reg[6:0], sda};
        bit_reg <= bit_reg + 1'b1;
      end else if (scl_rise && st_reg == PMT_TX) begin
        bit_reg <= bit_reg + 1'b1;
      end
      if (st_reg == PMT_ADDR && st_next == PMT_ACK) begin
        rd_reg <= sh_reg[0] | ara_match;
        ara_reg <= ara_match;
        first_reg <= ~sh_reg[0];
      end else if (st_reg == PMT_RX && st_next == PMT_ACK) begin
        first_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // line drive
  // ---------------------------------------------------------------
  logic [7:0] txs_reg;
  wire [7:0] tx_src = ara_reg ? {own_addr, 1'b0} : tx_data;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sda_drv_reg <= 1'b0;
      txs_reg <= 8'h00;
    end else if (clk_en) begin
      if (st_next == PMT_IDLE || st_next == PMT_SKIP) begin
        sda_drv_reg <= 1'b0;
      end else if (st_next == PMT_ACK && st_reg != PMT_ACK) begin
        sda_drv_reg <= 1'b1;
      end else if (st_reg == PMT_ACK && st_next == PMT_TX) begin
        txs_reg <= {tx_src[6:0], 1'b0};
        sda_drv_reg <= ~tx_src[7];
      end else if (st_reg == PMT_TX && scl_fall) begin
        txs_reg <= {txs_reg[6:0], 1'b0};
        sda_drv_reg <= bit_done ? 1'b0 : ~txs_reg[7];
      end else if (st_reg == PMT_TXACK && st_next == PMT_TX) begin
        // next read byte loads whole, first bit goes out on the next fall
        txs_reg <= tx_src;
      end else if (st_reg == PMT_ACK && st_next == PMT_RX) begin
        sda_drv_reg <= 1'b0;
      end
    end
  end

  assign serial_data_line_out = 1'b0;
  assign serial_data_line_oe = sda_drv_reg;
  assign serial_clock_line_out = 1'b0;
  assign serial_clock_line_oe = stretching;
  // alert is open drain, low while requested
  assign alert_n_out = 1'b0;
  assign alert_n_oe = alert_req;

  // ---------------------------------------------------------------
  // outputs to command layer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_byte <= '0;
      rx_read <= 1'b0;
      bus_stop <= 1'b0;
      timeout_evt <= 1'b0;
      idle_reset_evt <= 1'b0;
      in_msg_reg <= 1'b0;
    end else if (clk_en) begin
      // every command byte passes, standard or not
      rx_byte.valid <= (st_reg == PMT_RX) & (st_next == PMT_ACK);
      rx_byte.first <= first_reg;
      if (st_reg == PMT_RX && st_next == PMT_ACK) rx_byte.data <= sh_reg;
      rx_read <= (st_next == PMT_TX) &
                 ((st_reg == PMT_ACK) | (st_reg == PMT_TXACK));
      bus_stop <= stop_det & in_msg_reg;
      timeout_evt <= timeout_hit;
      idle_reset_evt <= idle_abort;
      if (stop_det || abort) in_msg_reg <= 1'b0;
      else if (start_det) in_msg_reg <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  timeout_release_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    timeout_hit && clk_en |=> st_reg == PMT_IDLE)
    else $error("transfer kept after clock low timeout");

  idle_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idle_reset_evt |-> !$past(smbus_timeout_disable_bit))
    else $error("idle reset while disable bit set");

  idle_reset_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    idle_abort && clk_en |=> !in_msg_reg)
    else $error("transaction survived idle reset");

  stretch_cap_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    serial_clock_line_oe |-> str_cnt_reg < CNT_W'(STRETCH_CYCLES))
    else $error("stretch budget exceeded");

  abort_free_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    abort && !start_det && clk_en |=> !serial_data_line_oe)
    else $error("data line held after abort");

  alert_pin_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    alert_n_oe == alert_req)
    else $error("alert pin not following request");

  addr_ack_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st_reg == PMT_ADDR && st_next == PMT_ACK |=> serial_data_line_oe)
    else $error("matching address not acknowledged");

  ara_reply_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clk_en && st_reg == PMT_ADDR && st_next == PMT_ACK && ara_match
    |=> rd_reg && ara_reg)
    else $error("alert response address not answered");
endmodule // pmt_target
`default_nettype wire

// file: verilog/pmt_pkg.sv
// package: constants and carrier types for the bus target interface
package pmt_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ = 25000000;
  localparam int unsigned TIMEOUT_MS = 35;
  localparam int unsigned IDLE_MS = 50;
  localparam int unsigned STRETCH_MS = 25;
  localparam int unsigned MIN_SCL_KHZ = 10;
  localparam int unsigned MAX_SCL_KHZ = 400;
  // longest times round down
  localparam int unsigned TIMEOUT_CYC = (REF_CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int unsigned IDLE_CYC = (REF_CLK_HZ / 1000) * IDLE_MS;
  localparam int unsigned STRETCH_CYC = (REF_CLK_HZ / 1000) * STRETCH_MS;
  localparam int unsigned CNT_W = 24;
  // ---------------------------------------------------------------
  // protocol
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_RESET = 7'h5A;
  // alert response address as it arrives, read bit included
  localparam logic [7:0] ARA_ADDR = 8'h19;
  localparam int unsigned BIT_CNT_RESET = 0;

  typedef enum logic [1:0] {
    PMT_EV_NONE,
    PMT_EV_CMD,
    PMT_EV_DATA,
    PMT_EV_STOP
  } pmt_ev_e;

  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } pmt_byte_s;

  typedef struct packed {
    logic scl_in;
    logic sda_in;
  } pmt_line_s;
endpackage : pmt_pkg

// file: verilog/pmt_sync.sv
// two-flop synchroniser for a group of level signals
`timescale 1ns/1ns
`default_nettype none
module pmt_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= {WIDTH{1'b1}};
      q <= {WIDTH{1'b1}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // pmt_sync
`default_nettype wire

// file: dv/pmt_host.sv
// host model: start, bits, stop, clock hold and bus park
`timescale 1ns/1ns
`default_nettype none
module pmt_host (
  input wire logic link_clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_oe,
  output logic sda_oe,
  output logic hung
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
    hung = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
  endtask
  // ------------------------------------------------------------
  // bus phases
  // ------------------------------------------------------------
  // release clock, wait out stretch
  task automatic rise();
    int w;
    w = 0;
    scl_oe <= 1'b0;
    tick(1);
    while (scl !== 1'b1 && w < 500) begin
      tick(1);
      w++;
    end
    hung <= hung | (w >= 500);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_oe <= ~b;
    tick(4);
    rise();
    tick(8);
    r = sda;
    scl_oe <= 1'b1;
    tick(4);
  endtask
  task automatic start();
    sda_oe <= 1'b1;
    tick(8);
    scl_oe <= 1'b1;
    tick(4);
  endtask
  task automatic stop();
    sda_oe <= 1'b1;
    tick(4);
    rise();
    tick(4);
    sda_oe <= 1'b0;
    tick(16);
  endtask
  // data freed while clock low, so neither start nor stop is seen
  task automatic park();
    sda_oe <= 1'b0;
    tick(4);
    rise();
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
endmodule // pmt_host
`default_nettype wire

// file: dv/pmt_target_tb.sv
// bench: table of transfers, then alert, stretch, timeout, idle reset
`timescale 1ns/1ns
`default_nettype none
module pmt_target_tb;
  import pmt_pkg::*;
  localparam int unsigned ST_C = 100;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic dis_bit = 1'b0;
  logic alert_req = 1'b0;
  logic hold_req = 1'b0;
  logic [7:0] tx_data = 8'h00;
  logic h_scl_oe, h_sda_oe, hung, d_sda_out, d_sda_oe, d_scl_out, d_scl_oe;
  logic alert_n_out, alert_n_oe, rx_read, bus_stop, timeout_evt, idle_evt;
  pmt_byte_s rx_byte;
  wire logic scl_w;
  wire logic sda_w;
  int fail_count = 0;
  int samples_checked = 0;
  int n_rd, n_stop, n_to, n_idle, n_st;
  logic [8:0] rxq[$];
  // rows: address, read, command, data, ack expected
  logic [24:0] rows [4] = '{
    {ADDR_RESET, 1'b0, 8'h01, 8'hA5, 1'b1},
    {ADDR_RESET, 1'b0, 8'hD0, 8'h3C, 1'b1},
    {ADDR_RESET, 1'b1, 8'h00, 8'hC3, 1'b1},
    {7'h2B, 1'b0, 8'h01, 8'h55, 1'b0}};
  // pull-ups: a released line reads high
  assign scl_w = ~h_scl_oe & (~d_scl_oe | d_scl_out);
  assign sda_w = ~h_sda_oe & (~d_sda_oe | d_sda_out);
  always #20 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  pmt_host host (.link_clk(link_clk), .scl(scl_w), .sda(sda_w),
    .scl_oe(h_scl_oe), .sda_oe(h_sda_oe), .hung(hung));
  // short counts keep the run small
  pmt_target #(.TIMEOUT_CYCLES(200), .IDLE_CYCLES(300),
    .STRETCH_CYCLES(ST_C)) dut (.ref_clk(ref_clk), .rst(rst),
    .clk_en(1'b1), .serial_clock_line(scl_w), .serial_data_line_in(sda_w),
    .serial_data_line_out(d_sda_out), .serial_data_line_oe(d_sda_oe),
    .serial_clock_line_out(d_scl_out), .serial_clock_line_oe(d_scl_oe),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .own_addr(ADDR_RESET), .smbus_timeout_disable_bit(dis_bit),
    .alert_req(alert_req), .hold_req(hold_req), .tx_data(tx_data),
    .rx_byte(rx_byte), .rx_read(rx_read), .bus_stop(bus_stop),
    .timeout_evt(timeout_evt), .idle_reset_evt(idle_evt));
  // ------------------------------------------------------------
  // event capture and checking
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (rx_byte.valid === 1'b1) rxq.push_back({rx_byte.first, rx_byte.data});
    n_rd += int'(rx_read === 1'b1);
    n_stop += int'(bus_stop === 1'b1);
    n_to += int'(timeout_evt === 1'b1);
    n_idle += int'(idle_evt === 1'b1);
    n_st += int'(d_scl_oe === 1'b1);
    if (hung === 1'b1) begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e,
                       input string m);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t %s seen %0h want %0h", $time, m, s, e);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic run_row(input logic [24:0] row);
    logic [6:0] a;
    logic rw, ea, k;
    logic [7:0] cmd, dat, q;
    {a, rw, cmd, dat, ea} = row;
    rxq.delete();
    n_stop = 0;
    n_rd = 0;
    @(posedge ref_clk);
    tx_data <= dat;
    host.start();
    host.xfer({a, rw}, q, k);
    check(k, ea, "addr ack");
    if (rw) begin
      host.xfer(8'hFF, q, k);
      check(q, dat, "read data");
      check(n_rd, 1, "read taken");
    end else begin
      host.xfer(cmd, q, k);
      host.xfer(dat, q, k);
      check(rxq.size(), 2 * ea, "byte count");
      if (ea) check({rxq[0], rxq[1]}, {1'b1, cmd, 1'b0, dat}, "bytes");
    end
    host.stop();
    if (ea) check(n_stop, 1, "stop seen");
  endtask
  // open a message, then leave both lines high well past the idle limit
  task automatic idle_try(input logic dis, input int exp);
    logic [7:0] q;
    logic k;
    @(posedge ref_clk);
    dis_bit <= dis;
    n_idle = 0;
    host.start();
    host.xfer({ADDR_RESET, 1'b0}, q, k);
    host.park();
    host.tick(100);
    check(n_idle, exp, "idle reset");
    run_row(rows[1]);
  endtask
  initial begin
    logic [7:0] q;
    logic k;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    check({d_sda_oe, d_scl_oe, alert_n_oe}, 3'b000, "reset lines");
    for (int i = 0; i < 4; i++) run_row(rows[i]);
    @(posedge ref_clk);
    alert_req <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check({alert_n_oe, alert_n_out}, 2'b10, "alert");
    host.start();
    host.xfer(ARA_ADDR, q, k);
    check(k, 1'b1, "ara ack");
    host.xfer(8'hFF, q, k);
    check(q, {ADDR_RESET, 1'b0}, "ara reply");
    host.stop();
    @(posedge ref_clk);
    alert_req <= 1'b0;
    hold_req <= 1'b1;
    n_st = 0;
    run_row(rows[0]);
    check(n_st > 0 && n_st <= ST_C, 1, "stretch budget");
    @(posedge ref_clk);
    hold_req <= 1'b0;
    tx_data <= 8'h00;
    n_to = 0;
    host.start();
    host.xfer({ADDR_RESET, 1'b1}, q, k);
    host.tick(10);
    check(d_sda_oe, 1'b1, "read drive");
    host.tick(60);
    check(n_to, 1, "clock timeout");
    check({d_sda_oe, d_scl_oe}, 2'b00, "lines freed");
    host.park();
    run_row(rows[1]);
    idle_try(1'b0, 1);
    idle_try(1'b1, 0);
    wrap_up();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge ref_clk);
    fail_count++;
    wrap_up();
  end
endmodule // pmt_target_tb
`default_nettype wire
